// *** common/sar_port_pkg.sv ***
// Shared constants and carrier types for the converter host port.
// Assumes a single 20 MHz system clock and synchronous active-high reset.
package sar_port_pkg;
	// Clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 50;
	// Result width and data bus width.
	localparam int RESULT_BITS = 12;
	// Configuration byte field positions.
	localparam int MODE_HI_POS = 7;
	localparam int MODE_LO_POS = 6;
	localparam int ACQ_POS = 5;
	localparam int SGL_POS = 4;
	localparam int UNI_POS = 3;
	localparam int CHAN_HI_POS = 2;
	// Acquisition time in nanoseconds and its derived cycle count.
	localparam int ACQ_TIME_NS = 1000;
	localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	// Conversion clock divider when the on-chip clock is used.
	localparam int INT_DIV = 2;
	// Configuration value after reset: full power-down, all fields zero.
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Power and clock mode field encodings.
	localparam logic [1:0] PM_FULL_DOWN = 2'h0;
	localparam logic [1:0] PM_STANDBY = 2'h1;
	localparam logic [1:0] PM_INT_CLK = 2'h2;
	localparam logic [1:0] PM_EXT_CLK = 2'h3;
	// Highest channel index on the six-channel variant.
	localparam logic [2:0] CHAN_MAX = 3'h5;

	// Routing of the sampler inputs.
	typedef struct packed {
		logic [2:0] pos_channel;
		logic neg_is_common;
		logic [2:0] neg_channel;
	} mux_sel_s;

	// One result word carried through the output buffer.
	typedef struct packed {
		logic [RESULT_BITS-1:0] code;
	} result_s;
endpackage

// *** dv/sar_host_model.sv ***
// Host processor and analog front model facing the converter port.
// Assumes the bench resolves the data lines against the device's oe.
`timescale 1ns/1ps
module sar_host_model
	import sar_port_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic ext_clk_in,
	input wire logic [RESULT_BITS-1:0] target_in,
	input wire logic [RESULT_BITS-1:0] dac_code_in,
	output logic comparator_out,
	output logic conv_clk_out,
	output logic chip_select_n_out,
	output logic read_n_out,
	output logic write_n_out,
	output logic [RESULT_BITS-1:0] host_bus_out
);
	logic [1:0] div_q; // Divider for the external conversion clock.
	// Idle host: deselected, strobes high, bus driven with the 12'hA5A filler.
	initial
	begin
		div_q = 2'h0;
		conv_clk_out = 1'b0;
		chip_select_n_out = 1'b1;
		read_n_out = 1'b1;
		write_n_out = 1'b1;
		host_bus_out = 12'hA5A;
	end
	// An input at or above the trial code keeps that bit.
	assign comparator_out = target_in >= dac_code_in;
	// Clock runs free in external mode and rests low otherwise.
	always @(posedge clk_sys_in)
	begin
		div_q <= div_q + 2'h1;
		conv_clk_out <= ext_clk_in & div_q[1];
	end
	// One selected strobe; each level is held long enough to be seen.
	task automatic strobe(input logic wr, input logic [7:0] b);
		@(posedge clk_sys_in);
		chip_select_n_out <= 1'b0;
		host_bus_out <= wr ? {4'h0, b} : host_bus_out;
		write_n_out <= !wr;
		read_n_out <= wr;
		repeat (6) @(posedge clk_sys_in);
		write_n_out <= 1'b1;
		read_n_out <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		chip_select_n_out <= 1'b1;
		host_bus_out <= ~host_bus_out;
		repeat (4) @(posedge clk_sys_in);
	endtask
endmodule // sar_host_model

// *** dv/sar_host_port_assertions.sv ***
// Checker for the converter host port pins and status outputs.
// Assumes it is bound to sar_host_port and sees only its ports.
`timescale 1ns/1ps
module sar_host_port_assertions
	import sar_port_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic chip_select_n_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic [RESULT_BITS-1:0] parallel_data_bus_oe_out,
	input wire logic done_n_out,
	input wire logic track_out,
	input wire mux_sel_s mux_sel_out,
	input wire logic powered_down_out,
	input wire logic standby_out
);
	// All checks share the system clock and its reset.
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	// A read held long enough to pass the pin synchronisers.
	sequence sel_read;
		(!chip_select_n_in && !read_n_in) [*5];
	endsequence
	// The sampler stops tracking and conversion begins.
	sequence conv_start;
		$fell(track_out);
	endsequence
	a_read_drives: assert property (
		sel_read |-> &parallel_data_bus_oe_out)
		else $error("bus not driven during read");
	a_cs_releases: assert property (
		chip_select_n_in [*5] |-> parallel_data_bus_oe_out == 12'h000)
		else $error("bus driven while deselected");
	a_rd_releases: assert property (
		read_n_in [*5] |-> parallel_data_bus_oe_out == 12'h000)
		else $error("bus driven without read");
	a_oe_whole: assert property (
		parallel_data_bus_oe_out == 12'h000 || &parallel_data_bus_oe_out)
		else $error("bus partly driven");
	a_conv_done: assert property (
		conv_start |-> ##[1:1000] !done_n_out)
		else $error("conversion never completed");
	a_done_holds: assert property (
		(read_n_in [*4] ##0 !done_n_out) |=> !done_n_out)
		else $error("completion dropped without read");
	a_mode_quiet: assert property (
		(powered_down_out || standby_out) |-> !track_out
		&& !(powered_down_out && standby_out))
		else $error("power-down mode misbehaves");
	a_mux_range: assert property (
		mux_sel_out.neg_is_common |-> mux_sel_out.pos_channel <= CHAN_MAX)
		else $error("channel out of range");
	a_track_on_write: assert property (
		$rose(track_out) |-> write_n_in)
		else $error("tracking began without write rise");
endmodule // sar_host_port_assertions

bind sar_host_port sar_host_port_assertions chk (.clk_sys_in, .rst_in,
	.chip_select_n_in, .read_n_in, .write_n_in, .parallel_data_bus_oe_out,
	.done_n_out, .track_out, .mux_sel_out, .powered_down_out, .standby_out);

// *** dv/sar_host_port_tb_top.sv ***
// Self-checking bench for the converter host port.
// Assumes the package, design, checker and host model compile first.
`timescale 1ns/1ps
module sar_host_port_tb_top
	import sar_port_pkg::*;
;
	logic clk_sys_in, rst_in, ext_clk, conv_clk, cs_n, rd_n, wr_n, comp;
	logic done_n, track, pd, sb, ovr, oe_q, ovr_seen;
	logic [11:0] bus_out, oe, host_bus, bus_in, dac, target;
	logic [11:0] exp_q[$]; // Expected words in read order.
	logic [11:0] t[3];
	mux_sel_s mux;
	int err_count, checks_done, cycles;
	logic [2:0] ch;
	assign bus_in = (oe & bus_out) | (~oe & host_bus);
	sar_host_port dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.chip_select_n_in(cs_n), .read_n_in(rd_n), .write_n_in(wr_n),
		.conv_clk_in(conv_clk), .parallel_data_bus_in(bus_in),
		.parallel_data_bus_out(bus_out), .parallel_data_bus_oe_out(oe),
		.done_n_out(done_n), .comparator_in(comp), .dac_code_out(dac),
		.track_out(track), .mux_sel_out(mux), .powered_down_out(pd),
		.standby_out(sb), .overrun_out(ovr));
	sar_host_model host (.clk_sys_in(clk_sys_in), .ext_clk_in(ext_clk),
		.target_in(target), .dac_code_in(dac), .comparator_out(comp),
		.conv_clk_out(conv_clk), .chip_select_n_out(cs_n),
		.read_n_out(rd_n), .write_n_out(wr_n), .host_bus_out(host_bus));
	// Free-running 20 MHz clock.
	initial
	begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	// Counts one comparison and reports a difference.
	task automatic compare(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("errors=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Starts a conversion on a fresh random level.
	task automatic convert(input logic [7:0] cfg, output logic [11:0] v);
		@(posedge clk_sys_in);
		v = 12'($urandom);
		target <= v;
		host.strobe(1'b1, cfg);
	endtask
	// Waits a bounded time for the completion output.
	task automatic wait_done();
		int n;
		n = 0;
		while (done_n !== 1'b0 && n < 2000)
		begin
			@(posedge clk_sys_in);
			n++;
		end
		compare(12'(done_n), 12'h0);
	endtask
	// Notes the expected word, then reads it.
	task automatic read_word(input logic [11:0] e);
		exp_q.push_back(e);
		host.strobe(1'b0, 8'h00);
	endtask
	// Watches reads, overruns and the cycle limit.
	always @(posedge clk_sys_in)
	begin
		oe_q <= &oe;
		cycles <= cycles + 1;
		if (&oe && !oe_q)
			compare(bus_out, exp_q.pop_front());
		if (ovr === 1'b1)
			ovr_seen <= 1'b1;
		if (cycles == 20000)
		begin
			err_count++;
			final_report();
		end
	end
	// Main sequence.
	initial
	begin
		err_count = 0;
		checks_done = 0;
		cycles = 0;
		oe_q = 1'b0;
		ovr_seen = 1'b0;
		rst_in = 1'b1;
		ext_clk = 1'b0;
		target = 12'h000;
		void'($urandom(32'h5cd34dc9));
		repeat (6) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		compare(12'({pd, sb, done_n}), 12'h5);
		// Power-down modes store the mode and start nothing.
		for (int m = 0; m < 2; m++)
		begin
			host.strobe(1'b1, 8'(m << 6));
			compare(12'({pd, sb, done_n, track}), m ? 12'h6 : 12'hA);
		end
		// Both clock modes and both acquisition modes.
		for (int i = 0; i < 4; i++)
		begin
			ch = 3'($urandom % 8);
			ext_clk <= i[0];
			convert({1'b1, i[0], i[1], 5'h18} | ch, t[0]);
			if (i[1])
			begin
				compare(12'(track), 12'h1);
				host.strobe(1'b1, 8'h00);
			end
			wait_done();
			// Codes above the last channel clamp to it.
			compare(12'({mux.pos_channel, mux.neg_is_common}),
				12'({((ch > CHAN_MAX) ? CHAN_MAX : ch), 1'b1}));
			read_word(t[0]);
		end
		// Three results against a two-entry buffer, then drain.
		ext_clk <= 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			convert(8'h8D, t[k]); // Differential pair 3 and 2.
			repeat (80) @(posedge clk_sys_in);
		end
		compare(12'(ovr_seen), 12'h1);
		compare(12'(mux), 12'h032);
		for (int k = 0; k < 4; k++)
			read_word(t[k > 2 ? 2 : k]);
		// Every noted read must have been answered on the bus.
		compare(12'(exp_q.size()), 12'h000);
		final_report();
	end
endmodule // sar_host_port_tb_top

// *** hdl/result_buffer.sv ***
// Two-entry valid/ready buffer that carries finished result words.
// Assumes both sides share the system clock and synchronous reset.
`timescale 1ns/1ps
module result_buffer
	import sar_port_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire result_s in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output result_s out_data_out
);
	// Storage slots addressed by index.
	result_s mem_q [2];
	result_s mem_d [2];
	logic wr_ptr_q, wr_ptr_d;
	logic rd_ptr_q, rd_ptr_d;
	logic [1:0] count_q, count_d;

	// Flags are honest: full at two entries, empty at zero.
	assign in_ready_out = (count_q != 2'h2);
	assign out_valid_out = (count_q != 2'h0);
	assign out_data_out = mem_q[rd_ptr_q];

	// Next-state computation for pointers, count and storage.
	always_comb
	begin
		logic push;
		logic pop;
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		mem_d = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (push)
		begin
			mem_d[wr_ptr_q] = in_data_in;
			wr_ptr_d = ~wr_ptr_q;
		end
		if (pop)
		begin
			rd_ptr_d = ~rd_ptr_q;
		end
		if (push && !pop)
		begin
			count_d = count_q + 2'h1;
		end
		else if (pop && !push)
		begin
			count_d = count_q - 2'h1;
		end
	end

	// Register stage.
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end
		else
		begin
			mem_q <= mem_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end
endmodule // result_buffer

// *** hdl/sar_host_port.sv ***
// Host-facing parallel port and conversion sequencer of a 12-bit SAR
// converter. Pins are asynchronous and pass two flip-flops first; the
// analog comparator result arrives as a plain input on the system clock.
`timescale 1ns/1ps
module sar_host_port
	import sar_port_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic chip_select_n_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic conv_clk_in,
	input wire logic [RESULT_BITS-1:0] parallel_data_bus_in,
	output logic [RESULT_BITS-1:0] parallel_data_bus_out,
	output logic [RESULT_BITS-1:0] parallel_data_bus_oe_out,
	output logic done_n_out,
	input wire logic comparator_in,
	output logic [RESULT_BITS-1:0] dac_code_out,
	output logic track_out,
	output mux_sel_s mux_sel_out,
	output logic powered_down_out,
	output logic standby_out,
	output logic overrun_out
);
	// Conversion sequencer states.
	typedef enum logic [2:0] {ST_IDLE, ST_ACQ_INT, ST_ACQ_EXT, ST_CONV,
		ST_STORE} seq_e;

	// Two-stage synchronisers for the asynchronous pins.
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [7:0] bus_s1_q;
	logic [7:0] bus_s2_q;
	// Previous synchronised levels for edge detection.
	logic rd_prev_q, wr_prev_q, clk_prev_q;
	// Sequencer state and working registers.
	seq_e state_q, state_d;
	logic [7:0] cfg_q, cfg_d;
	logic [RESULT_BITS-1:0] trial_q, trial_d;
	logic [RESULT_BITS-1:0] sar_q, sar_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] acq_cnt_q, acq_cnt_d;
	logic [1:0] div_q, div_d;
	logic done_q, done_d;
	logic track_q, track_d;
	logic overrun_q, overrun_d;
	logic [RESULT_BITS-1:0] hold_q, hold_d;
	logic [RESULT_BITS-1:0] dout_q, dout_d;
	logic drive_q, drive_d;
	mux_sel_s mux_q, mux_d;
	// Registered copies of the decoded outputs.
	logic [RESULT_BITS-1:0] dac_q, dac_d;
	logic done_n_q, done_n_d;
	logic pd_q, pd_d;
	logic sb_q, sb_d;
	// Buffer handshake.
	logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
	result_s buf_in_data, buf_out_data;

	// Synchronised pin views; only second stages are read.
	logic cs_n, rd_n, wr_n, ck;
	assign cs_n = pin_s2_q[0];
	assign rd_n = pin_s2_q[1];
	assign wr_n = pin_s2_q[2];
	assign ck = pin_s2_q[3];

	// Edge events derived from the second stage only.
	logic rd_fall, wr_rise, clk_fall, int_tick, step;
	assign rd_fall = !cs_n && rd_prev_q && !rd_n;
	assign wr_rise = !cs_n && !wr_prev_q && wr_n;
	assign clk_fall = clk_prev_q && !ck;
	assign int_tick = (div_q == 2'(INT_DIV - 1));
	// External clock mode steps on the falling pin clock; host keeps it
	// running, and the on-chip divider is used otherwise.
	assign step = (cfg_q[MODE_HI_POS:MODE_LO_POS] == PM_EXT_CLK) ?
		clk_fall : int_tick;

	// Output stage is taken from the buffer.
	assign buf_in_data.code = sar_q;
	assign buf_out_ready = rd_fall;

	result_buffer u_result_buffer
	(
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.in_valid_in(buf_in_valid),
		.in_ready_out(buf_in_ready),
		.in_data_in(buf_in_data),
		.out_valid_out(buf_out_valid),
		.out_ready_in(buf_out_ready),
		.out_data_out(buf_out_data)
	);

	// Synchroniser registers for pins and the low configuration byte.
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			// Clock pin bit rests low so no false fall follows reset.
			pin_s1_q <= 4'h7;
			pin_s2_q <= 4'h7;
			bus_s1_q <= 8'h00;
			bus_s2_q <= 8'h00;
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
			clk_prev_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= {conv_clk_in, write_n_in, read_n_in,
				chip_select_n_in};
			pin_s2_q <= pin_s1_q;
			bus_s1_q <= parallel_data_bus_in[7:0];
			bus_s2_q <= bus_s1_q;
			rd_prev_q <= rd_n;
			wr_prev_q <= wr_n;
			clk_prev_q <= ck;
		end
	end

	// Sequencer, configuration, result and bus next-state logic.
	always_comb
	begin
		state_d = state_q;
		cfg_d = cfg_q;
		trial_d = trial_q;
		sar_d = sar_q;
		bit_d = bit_q;
		acq_cnt_d = acq_cnt_q;
		div_d = int_tick ? 2'h0 : div_q + 2'h1;
		done_d = done_q;
		track_d = track_q;
		overrun_d = 1'b0;
		hold_d = hold_q;
		mux_d = mux_q;
		buf_in_valid = 1'b0;
		// A read takes the oldest result and lifts completion.
		if (rd_fall)
		begin
			done_d = 1'b0;
			if (buf_out_valid)
			begin
				hold_d = buf_out_data.code;
			end
		end
		case (state_q)
			ST_IDLE:
			begin
				if (wr_rise)
				begin
					cfg_d = bus_s2_q;
					// Bits five selects how acquisition ends.
					if (bus_s2_q[MODE_HI_POS] == 1'b0)
					begin
						state_d = ST_IDLE; // Power-down modes.
					end
					else if (bus_s2_q[ACQ_POS])
					begin
						state_d = ST_ACQ_EXT;
					end
					else
					begin
						state_d = ST_ACQ_INT;
						acq_cnt_d = 8'(ACQ_CYCLES);
					end
					track_d = bus_s2_q[MODE_HI_POS];
					// Single-ended routes to common.
					mux_d.neg_is_common = bus_s2_q[SGL_POS];
					if (bus_s2_q[SGL_POS])
					begin
						mux_d.pos_channel = (bus_s2_q[CHAN_HI_POS:0] >
							CHAN_MAX) ? CHAN_MAX : bus_s2_q[CHAN_HI_POS:0];
						mux_d.neg_channel = 3'h0;
					end
					else
					begin
						mux_d.pos_channel = {bus_s2_q[1:0], 1'b0} ^
							{2'h0, bus_s2_q[CHAN_HI_POS]};
						mux_d.neg_channel = {bus_s2_q[1:0], 1'b0} ^
							{2'h0, ~bus_s2_q[CHAN_HI_POS]};
					end
				end
			end
			ST_ACQ_INT:
			begin
				if (acq_cnt_q == 8'h00)
				begin
					state_d = ST_CONV;
					track_d = 1'b0;
					trial_d = 12'h800;
					sar_d = 12'h000;
					bit_d = 4'hB;
				end
				else
				begin
					acq_cnt_d = acq_cnt_q - 8'h01;
				end
			end
			ST_ACQ_EXT:
			begin
				// The next write rise ends tracking.
				if (wr_rise)
				begin
					state_d = ST_CONV;
					track_d = 1'b0;
					trial_d = 12'h800;
					sar_d = 12'h000;
					bit_d = 4'hB;
				end
			end
			ST_CONV:
			begin
				// One bit decided per conversion clock.
				if (step)
				begin
					if (comparator_in)
					begin
						sar_d = sar_q | trial_q;
					end
					trial_d = trial_q >> 1;
					if (bit_q == 4'h0)
					begin
						state_d = ST_STORE;
					end
					else
					begin
						bit_d = bit_q - 4'h1;
					end
				end
			end
			ST_STORE:
			begin
				buf_in_valid = 1'b1;
				if (buf_in_ready)
				begin
					state_d = ST_IDLE;
					done_d = 1'b1;
				end
				else
				begin
					overrun_d = 1'b1; // Unread results stall here.
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
		// Drive only while select and read are both low.
		drive_d = !cs_n && !rd_n;
		dout_d = rd_fall && buf_out_valid ? buf_out_data.code : hold_q;
		// Output copies follow the next values so they stay in step.
		dac_d = sar_d | trial_d;
		done_n_d = !done_d;
		pd_d = (cfg_d[MODE_HI_POS:MODE_LO_POS] == PM_FULL_DOWN);
		sb_d = (cfg_d[MODE_HI_POS:MODE_LO_POS] == PM_STANDBY);
	end

	// Register stage for the sequencer and bus.
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			state_q <= ST_IDLE;
			cfg_q <= CFG_RESET;
			trial_q <= 12'h000;
			sar_q <= 12'h000;
			bit_q <= 4'h0;
			acq_cnt_q <= 8'h00;
			div_q <= 2'h0;
			done_q <= 1'b0;
			track_q <= 1'b0;
			overrun_q <= 1'b0;
			hold_q <= 12'h000;
			dout_q <= 12'h000;
			drive_q <= 1'b0;
			mux_q <= '0;
			dac_q <= 12'h000;
			done_n_q <= 1'b1;
			pd_q <= (CFG_RESET[MODE_HI_POS:MODE_LO_POS] == PM_FULL_DOWN);
			sb_q <= (CFG_RESET[MODE_HI_POS:MODE_LO_POS] == PM_STANDBY);
		end
		else
		begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			trial_q <= trial_d;
			sar_q <= sar_d;
			bit_q <= bit_d;
			acq_cnt_q <= acq_cnt_d;
			div_q <= div_d;
			done_q <= done_d;
			track_q <= track_d;
			overrun_q <= overrun_d;
			hold_q <= hold_d;
			dout_q <= dout_d;
			drive_q <= drive_d;
			mux_q <= mux_d;
			dac_q <= dac_d;
			done_n_q <= done_n_d;
			pd_q <= pd_d;
			sb_q <= sb_d;
		end
	end

	// Outputs straight from flip-flops.
	assign parallel_data_bus_out = dout_q;
	assign parallel_data_bus_oe_out = {RESULT_BITS{drive_q}};
	assign done_n_out = done_n_q;
	assign dac_code_out = dac_q;
	assign track_out = track_q;
	assign mux_sel_out = mux_q;
	assign powered_down_out = pd_q;
	assign standby_out = sb_q;
	assign overrun_out = overrun_q;
endmodule // sar_host_port
